// [flic_pkg.sv]
// package for the four level interrupt controller
package flic_pkg;
  // ----------------------------------------
  // register map (axi4-lite byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_ENABLE = 8'h00; // interrupt_enable_reg
  localparam logic [7:0] ADDR_PRIO_LOW = 8'h04; // priority_low_bits
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'h08; // priority_high_bits
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h0c; // ext_int_control
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10; // sticky events, w1c
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14; // event mask
  localparam logic [7:0] ADDR_STATE = 8'h18; // in-service and winner view
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int EN_GLOBAL_BIT = 7; // global_irq_enable
  localparam int XC_EXT2_EN_BIT = 2; // ext2_enable
  localparam int XC_EXT2_PL_BIT = 3; // ext2_priority_low
  localparam int XC_EXT3_EN_BIT = 6; // ext3_enable
  localparam int XC_EXT3_PL_BIT = 7; // ext3_priority_low
  localparam int EV_VECTOR_BIT = 0; // status: vector call issued
  localparam int EV_RETURN_BIT = 1; // status: isr_return seen
  localparam int EV_WAKE_BIT = 2; // status: wakeup raised
  // ----------------------------------------
  // source numbering in ranking order
  // ----------------------------------------
  localparam int NSRC = 8;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_TIMER1 = 3'h3;
  localparam logic [2:0] SRC_SERIAL = 3'h4;
  localparam logic [2:0] SRC_TIMER2 = 3'h5;
  localparam logic [2:0] SRC_EXT2 = 3'h6;
  localparam logic [2:0] SRC_EXT3 = 3'h7;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CALL_CYCLES = 4; // machine cycles of a vector call
  localparam logic [2:0] CALL_LAST = 3'h3; // last call cycle index
  localparam logic [15:0] VEC_BASE = 16'h0003; // ext0 vector
  localparam logic [15:0] VEC_STEP = 16'h0008; // vector spacing
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, // polling
    ST_CALL = 2'b01 // vector call in progress
  } flic_state_t;
  typedef struct packed {
    logic [7:0] ext_flags; // ext0..ext3 at 0,1,2,3 and spare
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_overflow_flag;
    logic timer2_ext_flag;
    logic uart_rx_flag;
    logic uart_tx_flag;
  } flic_flags_t;
  typedef struct packed {
    logic last_cycle; // final machine cycle of instruction
    logic is_isr_return; // instruction is isr_return
    logic is_subroutine_exit; // instruction is subroutine_exit
    logic writes_irq_regs; // writes enable/priority/ext control
  } flic_cpu_t;
endpackage

// [flic_ctrl.sv]
// four level interrupt controller with axi4-lite registers
`timescale 1ns/1ps
module flic_ctrl (
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic mc_strobe, // one pulse per machine cycle
  input wire flic_pkg::flic_flags_t flags, // source flags
  input wire logic [1:0] ext01_edge_mode, // ext0/ext1 edge mode
  input wire flic_pkg::flic_cpu_t cpu, // instruction status
  input wire logic [15:0] pc_in, // pc to push
  output logic call_req, // vector call active
  output logic [15:0] call_vector, // vector for pc
  output logic push_pc, // push pc pulse
  output logic [15:0] push_value, // pushed pc
  output logic pop_pc, // pop pc pulse
  output logic [3:0] clear_flags, // clear t0,t1,e0,e1 pulse
  output logic wakeup, // power-down wake
  output logic irq, // status interrupt
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready // read ready
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    flic_pkg::flic_state_t st; // sequencer state
    logic [2:0] cyc; // call cycle count
    logic [2:0] win; // latched winner
    logic [1:0] wlvl; // latched winner level
    logic [3:0] in_service; // one per level
    logic [7:0] en; // interrupt_enable_reg
    logic [7:0] plo; // priority_low_bits
    logic [7:0] phi; // priority_high_bits
    logic [7:0] xc; // ext_int_control
    logic [2:0] ists; // sticky events
    logic [2:0] imask; // event mask
    logic [7:0] req_smp; // sampled requests
    logic call_req;
    logic [15:0] call_vector;
    logic push_pc;
    logic [15:0] push_value;
    logic pop_pc;
    logic [3:0] clear_flags;
    logic wakeup;
    logic irq;
    logic aw_hold; // write address taken
    logic [7:0] awa;
    logic w_hold; // write data taken
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready, wready, arready; // registered readies
  } flic_regs_t;
  flic_regs_t r;
  flic_regs_t next_r;

  // level of a source from its two priority bits
  function automatic logic [1:0] src_level(input logic hi, input logic lo);
    src_level = {hi, lo};
  endfunction

  // vector of a source index
  function automatic logic [15:0] src_vector(input logic [2:0] s);
    src_vector = flic_pkg::VEC_BASE + 16'(s) * flic_pkg::VEC_STEP;
  endfunction

  // byte-lane merge of a write
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  // ----------------------------------------
  // request and arbitration logic
  // ----------------------------------------
  logic [7:0] raw_req; // source requests
  logic [7:0] src_en; // per-source enables
  logic [1:0] lvl [flic_pkg::NSRC]; // level per source
  logic [2:0] pick; // chosen source
  logic [1:0] pick_lvl; // its level
  logic pick_ok; // some request
  logic [1:0] top_is; // highest level in service
  logic any_is; // any level in service
  logic may_call; // conditions met

  always_comb begin
    // requests, serial and timer2 are ORed pairs
    raw_req = {flags.ext_flags[3], flags.ext_flags[2],
               flags.timer2_overflow_flag | flags.timer2_ext_flag,
               flags.uart_rx_flag | flags.uart_tx_flag,
               flags.timer1_overflow_flag, flags.ext_flags[1],
               flags.timer0_overflow_flag, flags.ext_flags[0]};
    // enables, ext2/ext3 live in ext control
    src_en = {r.xc[flic_pkg::XC_EXT3_EN_BIT], r.xc[flic_pkg::XC_EXT2_EN_BIT],
              r.en[5], r.en[4], r.en[3], r.en[2], r.en[1], r.en[0]};
    if (!r.en[flic_pkg::EN_GLOBAL_BIT]) begin
      src_en = 8'h00;
    end
    // priority per source
    for (int i = 0; i < 6; i++) begin
      lvl[i] = src_level(r.phi[i], r.plo[i]);
    end
    lvl[6] = src_level(r.phi[6], r.xc[flic_pkg::XC_EXT2_PL_BIT]);
    lvl[7] = src_level(r.phi[7], r.xc[flic_pkg::XC_EXT3_PL_BIT]);
    // highest level first, lowest index within a level
    pick = 3'h0;
    pick_lvl = 2'h0;
    pick_ok = 1'b0;
    for (int i = flic_pkg::NSRC - 1; i >= 0; i--) begin
      if (r.req_smp[i] && (!pick_ok || lvl[i] >= pick_lvl)) begin
        pick = 3'(i);
        pick_lvl = lvl[i];
        pick_ok = 1'b1;
      end
    end
    // highest active in-service level
    top_is = 2'h0;
    any_is = |r.in_service;
    for (int l = 0; l < 4; l++) begin
      if (r.in_service[l]) begin
        top_is = 2'(l);
      end
    end
    // strictly higher than anything in service
    may_call = pick_ok && (!any_is || pick_lvl > top_is)
               && cpu.last_cycle && !cpu.is_isr_return
               && !cpu.writes_irq_regs && r.st == flic_pkg::ST_RUN;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic aw_take, w_take, ar_take;
  logic [7:0] waddr;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic do_write;
  logic [2:0] ev;

  always_comb begin
    next_r = r;
    ev = 3'h0;
    next_r.push_pc = 1'b0;
    next_r.pop_pc = 1'b0;
    next_r.clear_flags = 4'h0;
    // sample flags each machine cycle, nothing kept past it
    if (mc_strobe) begin
      next_r.req_smp = raw_req & src_en;
    end
    // sequencer
    case (r.st)
      flic_pkg::ST_RUN: begin
        if (mc_strobe && may_call) begin
          next_r.st = flic_pkg::ST_CALL;
          next_r.cyc = 3'h0;
          next_r.win = pick;
          next_r.wlvl = pick_lvl;
          next_r.call_req = 1'b1;
          next_r.call_vector = src_vector(pick);
          next_r.in_service[pick_lvl] = 1'b1;
          next_r.push_pc = 1'b1;
          next_r.push_value = pc_in;
          next_r.clear_flags = {ext01_edge_mode[1] && pick == flic_pkg::SRC_EXT1,
                                ext01_edge_mode[0] && pick == flic_pkg::SRC_EXT0,
                                pick == flic_pkg::SRC_TIMER1,
                                pick == flic_pkg::SRC_TIMER0};
          ev[flic_pkg::EV_VECTOR_BIT] = 1'b1;
        end else if (mc_strobe && cpu.last_cycle && cpu.is_isr_return) begin
          next_r.pop_pc = 1'b1;
          if (any_is) begin
            next_r.in_service[top_is] = 1'b0;
          end
          ev[flic_pkg::EV_RETURN_BIT] = 1'b1;
        end else if (mc_strobe && cpu.last_cycle && cpu.is_subroutine_exit) begin
          next_r.pop_pc = 1'b1;
        end
      end
      flic_pkg::ST_CALL: begin
        if (mc_strobe) begin
          next_r.cyc = r.cyc + 3'h1;
          if (r.cyc == flic_pkg::CALL_LAST) begin
            next_r.st = flic_pkg::ST_RUN;
            next_r.call_req = 1'b0;
          end
        end
      end
      default: begin
        next_r.st = flic_pkg::ST_RUN;
      end
    endcase
    // wake only from enabled external sources
    next_r.wakeup = |(raw_req & src_en & 8'hc5);
    if (next_r.wakeup && !r.wakeup) begin
      ev[flic_pkg::EV_WAKE_BIT] = 1'b1;
    end
    // axi4-lite write side
    aw_take = s_axi_awvalid && r.awready;
    w_take = s_axi_wvalid && r.wready;
    if (aw_take) begin
      next_r.aw_hold = 1'b1;
      next_r.awa = s_axi_awaddr;
    end
    if (w_take) begin
      next_r.w_hold = 1'b1;
      next_r.wd = s_axi_wdata;
      next_r.ws = s_axi_wstrb;
    end
    waddr = aw_take ? s_axi_awaddr : r.awa;
    wdat = w_take ? s_axi_wdata : r.wd;
    wstb = w_take ? s_axi_wstrb : r.ws;
    do_write = (aw_take || r.aw_hold) && (w_take || r.w_hold) && !r.bvalid;
    if (do_write) begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'b00;
      case (waddr)
        flic_pkg::ADDR_ENABLE: next_r.en = lane0(r.en, wdat, wstb);
        flic_pkg::ADDR_PRIO_LOW: next_r.plo = lane0(r.plo, wdat, wstb);
        flic_pkg::ADDR_PRIO_HIGH: next_r.phi = lane0(r.phi, wdat, wstb);
        flic_pkg::ADDR_EXT_CTRL: next_r.xc = lane0(r.xc, wdat, wstb);
        flic_pkg::ADDR_IRQ_STATUS: begin
          if (wstb[0]) begin
            next_r.ists = r.ists & ~wdat[2:0];
          end
        end
        flic_pkg::ADDR_IRQ_MASK: begin
          if (wstb[0]) begin
            next_r.imask = wdat[2:0];
          end
        end
        flic_pkg::ADDR_STATE: next_r.bresp = 2'b00;
        default: next_r.bresp = 2'b10; // unmapped: slverr
      endcase
    end else if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // events set after clear so a set wins
    next_r.ists = next_r.ists | ev;
    next_r.irq = |(next_r.ists & next_r.imask);
    // axi4-lite read side
    ar_take = s_axi_arvalid && r.arready;
    if (ar_take) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'b00;
      case (s_axi_araddr)
        flic_pkg::ADDR_ENABLE: next_r.rdata = {24'h000000, r.en};
        flic_pkg::ADDR_PRIO_LOW: next_r.rdata = {24'h000000, r.plo};
        flic_pkg::ADDR_PRIO_HIGH: next_r.rdata = {24'h000000, r.phi};
        flic_pkg::ADDR_EXT_CTRL: next_r.rdata = {24'h000000, r.xc};
        flic_pkg::ADDR_IRQ_STATUS: next_r.rdata = {29'h00000000, r.ists};
        flic_pkg::ADDR_IRQ_MASK: next_r.rdata = {29'h00000000, r.imask};
        flic_pkg::ADDR_STATE: next_r.rdata = {16'h0000, r.call_req, r.win,
                                              r.wlvl, 6'h00, r.in_service};
        default: begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = 2'b10;
        end
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    // readies from flops, low for one cycle after reset
    next_r.awready = !next_r.aw_hold && !next_r.bvalid;
    next_r.wready = !next_r.w_hold && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  // ----------------------------------------
  // register the state
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign call_req = r.call_req;
  assign call_vector = r.call_vector;
  assign push_pc = r.push_pc;
  assign push_value = r.push_value;
  assign pop_pc = r.pop_pc;
  assign clear_flags = r.clear_flags;
  assign wakeup = r.wakeup;
  assign irq = r.irq;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_call_start;
    r.st == flic_pkg::ST_RUN && mc_strobe && may_call;
  endsequence

  AST_CALL_PUSH: assert property (@(posedge aclk) disable iff (!aresetn)
    s_call_start |=> push_pc && call_req && push_value == $past(pc_in))
    else $error("vector call did not push pc");
  AST_CALL_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn)
    s_call_start |=> call_vector == 16'h0003 + {13'h0, $past(pick)} * 16'h0008)
    else $error("wrong vector");
  AST_NO_CALL_RETURN: assert property (@(posedge aclk) disable iff (!aresetn)
    r.st == flic_pkg::ST_RUN && (cpu.is_isr_return || cpu.writes_irq_regs
      || !cpu.last_cycle) |=> !push_pc)
    else $error("call in forbidden cycle");
  AST_PREEMPT: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_call_start and any_is) |-> pick_lvl > top_is)
    else $error("preempt by equal or lower level");
  AST_IN_SERVICE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_call_start |=> r.in_service[$past(pick_lvl)])
    else $error("in-service not set");
  AST_GLOBAL_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    mc_strobe && !r.en[7] |=> r.req_smp == 8'h00)
    else $error("global disable ignored");
  AST_T0_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_call_start and pick == 3'h1) |=> clear_flags == 4'h1)
    else $error("timer0 flag not cleared");
  AST_NO_WAKE_TIMER: assert property (@(posedge aclk) disable iff (!aresetn)
    (raw_req & src_en & 8'hc5) == 8'h00 |=> !wakeup)
    else $error("wake from non-external source");
endmodule

// [flic_cpu_model.sv]
// behavioural cpu sequencer and return stack facing the interrupt controller
`timescale 1ns/1ps
module flic_cpu_model #(
  parameter int MC_CLKS = 4, // clocks per machine cycle
  parameter logic [15:0] PC_HOME = 16'h0a5c // pc of the interrupted program
) (
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [3:0] knob, // last, isr_return, subroutine_exit, reg write
  input wire logic call_req, // vector call active
  input wire logic [15:0] call_vector, // vector for pc
  input wire logic push_pc, // push pulse
  input wire logic [15:0] push_value, // value to push
  input wire logic pop_pc, // pop pulse
  output logic mc_strobe, // one pulse per machine cycle
  output flic_pkg::flic_cpu_t cpu, // instruction status
  output logic [15:0] pc_in // current pc
);
  logic [7:0] cnt; // clock count inside machine cycle
  logic [15:0] stack [0:7]; // return stack
  logic [2:0] sp; // stack depth
  logic call_q; // call_req one cycle ago
  // instruction status held level by the bench knobs
  assign cpu = flic_pkg::flic_cpu_t'(knob);
  // ----------------------------------------
  // machine cycle strobe, stack and pc
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
      mc_strobe <= 1'b0;
      sp <= 3'h0;
      call_q <= 1'b0;
      pc_in <= PC_HOME;
    end else begin
      cnt <= (cnt == 8'(MC_CLKS - 1)) ? 8'h00 : cnt + 8'h01;
      mc_strobe <= (cnt == 8'(MC_CLKS - 1));
      call_q <= call_req;
      if (push_pc) begin // saves the pc like a long call
        stack[sp] <= push_value;
        sp <= sp + 3'h1;
      end else if (pop_pc && sp != 3'h0) begin // return reloads pc
        pc_in <= stack[sp - 3'h1];
        sp <= sp - 3'h1;
      end else if (call_q && !call_req) begin // call done, jump to vector
        pc_in <= call_vector;
      end
    end
  end
endmodule

// [flic_ctrl_test.sv]
// self-checking testbench of the four level interrupt controller
`timescale 1ns/1ps
module flic_ctrl_test;
  localparam logic [15:0] PC_HOME = 16'h0a5c; // pc of interrupted program
  logic aclk, aresetn, mc_strobe, call_req, push_pc, pop_pc, wakeup, irq; // core pins
  flic_pkg::flic_flags_t flags; // source flags
  flic_pkg::flic_cpu_t cpu; // instruction status
  logic [1:0] edge_mode; // ext0 edge, ext1 level
  logic [15:0] pc_in, call_vector, push_value; // pc traffic
  logic [3:0] clear_flags, knob; // flag clears, sequencer knobs
  logic [7:0] awaddr, araddr; // axi addresses
  logic [31:0] wdata, rdata; // axi data
  logic [3:0] wstrb; // byte enables
  logic [1:0] bresp, rresp; // axi responses
  logic awvalid, awready, wvalid, wready, bvalid, bready; // write handshakes
  logic arvalid, arready, rvalid, rready; // read handshakes
  int errors, comparisons; // mismatch and compare counts
  logic [31:0] d; // scratch read data
  logic [1:0] r; // scratch response
  flic_ctrl flic_ctrl_i (.aclk(aclk), .aresetn(aresetn), .mc_strobe(mc_strobe), .flags(flags),
    .ext01_edge_mode(edge_mode), .cpu(cpu), .pc_in(pc_in), .call_req(call_req),
    .call_vector(call_vector), .push_pc(push_pc), .push_value(push_value), .pop_pc(pop_pc),
    .clear_flags(clear_flags), .wakeup(wakeup), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  flic_cpu_model #(.MC_CLKS(4), .PC_HOME(PC_HOME)) flic_cpu_model_i (.aclk(aclk),
    .aresetn(aresetn), .knob(knob), .call_req(call_req), .call_vector(call_vector),
    .push_pc(push_pc), .push_value(push_value), .pop_pc(pop_pc), .mc_strobe(mc_strobe),
    .cpu(cpu), .pc_in(pc_in));
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (100000) @(posedge aclk);
    errors++;
    end_sim;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim;
    $display("counts: %0d mismatches, %0d comparisons", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    bit aw_ok, w_ok;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    aw_ok = 0;
    w_ok = 0;
    for (n = 0; n < 100 && !(aw_ok && w_ok && bvalid === 1'b1); n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin aw_ok = 1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin w_ok = 1; wvalid <= 1'b0; end
      r = bresp;
    end
    bready <= 1'b0;
    if (n == 100) begin errors++; $display("ERROR at %0t: write timed out", $time); end_sim; end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (n = 0; n < 100 && rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
    if (n == 100) begin errors++; $display("ERROR at %0t: read timed out", $time); end_sim; end
  endtask
  task automatic st_chk(input logic [3:0] e);
    repeat (2) @(posedge aclk);
    axi_rd(flic_pkg::ADDR_STATE);
    chk(d & 32'hf, {28'h0, e}, "in-service levels");
  endtask
  task automatic set_src(input int s, input logic v);
    case (s)
      0: flags.ext_flags[0] <= v;
      1: flags.timer0_overflow_flag <= v;
      2: flags.ext_flags[1] <= v;
      3: flags.timer1_overflow_flag <= v;
      4: flags.uart_tx_flag <= v;
      5: flags.timer2_ext_flag <= v;
      6: flags.ext_flags[2] <= v;
      default: flags.ext_flags[3] <= v;
    endcase
  endtask
  task automatic mc_edge;
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (mc_strobe === 1'b1) break;
    end
    if (n == 50) begin errors++; $display("ERROR at %0t: no strobe", $time); end_sim; end
  endtask
  task automatic call_done; // wait for the vector call to end
    int n;
    for (n = 0; n < 100 && call_req !== 1'b0; n++) @(posedge aclk);
    if (n == 100) begin errors++; $display("ERROR at %0t: call never ended", $time); end_sim; end
  endtask
  task automatic instr(input logic [3:0] k); // one machine cycle of instruction kind k
    mc_edge;
    knob <= k;
    mc_edge;
    knob <= 4'h8;
  endtask
  task automatic wait_call(input logic [15:0] v);
    int n;
    for (n = 0; n < 300 && push_pc !== 1'b1; n++) @(posedge aclk);
    if (n == 300) begin errors++; $display("ERROR at %0t: no vector call", $time); end_sim; end
    chk(32'(call_vector), 32'(v), "vector");
  endtask
  task automatic no_call(input int k);
    repeat (k * 4) begin
      @(posedge aclk);
      chk(32'(push_pc), 32'h0, "unexpected call");
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(32'({call_req, irq, push_pc}), 32'h0, "outputs after reset");
    axi_rd(flic_pkg::ADDR_STATE);
    chk(d, 32'h0, "state after reset");
    axi_rd(8'h1c);
    chk(32'(r), 32'h2, "unmapped read");
    axi_wr(8'h20, 32'h1);
    chk(32'(r), 32'h2, "unmapped write");
    $display("test reset done");
  endtask
  task automatic t_vectors;
    int s, n, k;
    logic [3:0] ce;
    axi_wr(flic_pkg::ADDR_ENABLE, 32'hbf);
    axi_wr(flic_pkg::ADDR_EXT_CTRL, 32'h44);
    for (s = 0; s < 8; s++) begin
      set_src(s, 1'b1);
      wait_call(16'h0003 + 16'(s) * 16'h0008 + ((s == 2) ? 16'h0000 : 16'h0000));
      ce = (s == 0) ? 4'h4 : (s == 1) ? 4'h1 : (s == 3) ? 4'h2 : 4'h0;
      chk(32'(clear_flags), 32'(ce), "flag clears");
      chk(32'(push_value), 32'(PC_HOME), "pushed pc");
      chk(32'(wakeup), 32'(s == 0 || s == 2 || s == 6 || s == 7), "wakeup");
      n = 0;
      for (k = 0; k < 100 && call_req === 1'b1; k++) begin
        if (mc_strobe === 1'b1) n++;
        @(posedge aclk);
      end
      chk(n, flic_pkg::CALL_CYCLES, "call length");
      set_src(s, 1'b0);
      instr(4'hc);
      st_chk(4'h0);
      chk(32'(pc_in), 32'(PC_HOME), "pc after return");
    end
    $display("test vectors done");
  endtask
  task automatic t_levels;
    axi_wr(flic_pkg::ADDR_PRIO_LOW, 32'h02);
    axi_wr(flic_pkg::ADDR_PRIO_HIGH, 32'h80);
    axi_wr(flic_pkg::ADDR_EXT_CTRL, 32'hc4);
    set_src(1, 1'b1);
    wait_call(16'h000b);
    set_src(1, 1'b0);
    st_chk(4'b0010);
    set_src(7, 1'b1);
    wait_call(16'h003b);
    set_src(7, 1'b0);
    st_chk(4'b1010);
    call_done;
    instr(4'ha);
    st_chk(4'b1010);
    set_src(0, 1'b1);
    no_call(6);
    instr(4'hc);
    st_chk(4'b0010);
    no_call(4);
    instr(4'hc);
    wait_call(16'h0003);
    set_src(0, 1'b0);
    call_done;
    instr(4'hc);
    st_chk(4'h0);
    $display("test levels done");
  endtask
  task automatic t_rank;
    axi_wr(flic_pkg::ADDR_PRIO_LOW, 32'h00);
    axi_wr(flic_pkg::ADDR_EXT_CTRL, 32'h44);
    flags <= '1;
    wait_call(16'h003b);
    call_done;
    flags.ext_flags[3] <= 1'b0;
    instr(4'hc);
    wait_call(16'h0003);
    flags <= '0;
    call_done;
    instr(4'hc);
    st_chk(4'h0);
    axi_wr(flic_pkg::ADDR_PRIO_HIGH, 32'h00);
    $display("test ranking done");
  endtask
  task automatic t_refuse;
    knob <= 4'h0;
    set_src(3, 1'b1);
    no_call(4);
    set_src(3, 1'b0);
    no_call(2);
    knob <= 4'h8;
    no_call(4);
    set_src(3, 1'b1);
    knob <= 4'h9;
    no_call(3);
    knob <= 4'hc;
    no_call(3);
    knob <= 4'h9;
    axi_wr(flic_pkg::ADDR_ENABLE, 32'h3f);
    mc_edge;
    knob <= 4'h8;
    no_call(3);
    knob <= 4'h9;
    axi_wr(flic_pkg::ADDR_ENABLE, 32'hbf);
    knob <= 4'h8;
    wait_call(16'h001b);
    set_src(3, 1'b0);
    call_done;
    instr(4'hc);
    st_chk(4'h0);
    $display("test refusal done");
  endtask
  task automatic t_irq;
    axi_wr(flic_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1, "irq raised");
    axi_wr(flic_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0, "irq masked");
    axi_wr(flic_pkg::ADDR_IRQ_STATUS, 32'h7);
    axi_rd(flic_pkg::ADDR_IRQ_STATUS);
    chk(d, 32'h0, "status cleared");
    $display("test interrupt done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, flags, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    edge_mode = 2'b01;
    knob = 4'h8;
    errors = 0;
    comparisons = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_vectors;
    t_levels;
    t_rank;
    t_refuse;
    t_irq;
    end_sim;
  end
endmodule
